/* File: core/prescaled_reload_down_timer.sv */
/*
  Reload down timer with prescaler, gating, auto restart and protocol
  start/stop, reached over an AHB-Lite slave. Assumes hclk is the timer
  reference and protocol event inputs are one-cycle pulses on hclk.
*/
`timescale 1ns/1ps
`include "timer_consts.svh"
module prescaled_reload_down_timer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_test_input_pin,
  input  wire logic        first_auxiliary_pin,
  input  wire logic        address_pin_three,
  input  wire logic        tx_end,
  input  wire logic        field_on,
  input  wire logic        rx_bit,
  input  wire logic        fast_106_mode,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  logic       wr_pend_reg;
  logic [5:0] wr_idx_reg;
  logic       rd_pend_reg;
  logic [5:0] rd_idx_reg;
  logic [7:0] hrdata_reg;
  logic       take;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;
  timer_if    tif ();

  // pure function: a continuous assign re-evaluates only on its arguments
  function automatic logic hit(input logic pend, input logic [5:0] at, input logic [5:0] idx);
    hit = pend && (at == idx);
  endfunction

  assign take      = hsel & hready & htrans[1];
  assign wbyte     = hwdata[7:0];
  // reads take one wait cycle so a prior write is visible
  assign hreadyout = ~rd_pend_reg;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h00_0000, hrdata_reg};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 6'h00;
      rd_pend_reg <= 1'b0;
      rd_idx_reg  <= 6'h00;
      hrdata_reg  <= `RESET_BYTE;
    end
    else
    begin
      wr_pend_reg <= take & hwrite;
      rd_pend_reg <= take & ~hwrite;
      if (take)
      begin
        wr_idx_reg <= haddr[7:2];
        rd_idx_reg <= haddr[7:2];
      end
      if (rd_pend_reg)
        hrdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  mode_reg;
  logic [7:0]  presc_low_reg;
  logic [7:0]  reload_high_reg;
  logic [7:0]  reload_low_reg;
  logic [4:0]  control_reg;
  logic [1:0]  mask_reg;
  logic [15:0] count_reg;
  logic        active;
  logic [1:0]  gate_source_select;
  logic        auto_reload_on_expiry;
  logic        protocol_auto_start;
  logic        multiple_reception_enable;
  logic        initial_field_on_option;
  logic [15:0] reload_value;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg        <= `RESET_BYTE;
      presc_low_reg   <= `RESET_BYTE;
      reload_high_reg <= `RESET_BYTE;
      reload_low_reg  <= `RESET_BYTE;
      control_reg     <= 5'h00;
      mask_reg        <= 2'h0;
    end
    else
    begin
      if (hit(wr_pend_reg, wr_idx_reg, `IDX_MODE))
        mode_reg <= wbyte;
      if (hit(wr_pend_reg, wr_idx_reg, `IDX_PRESC_LOW))
        presc_low_reg <= wbyte;
      if (hit(wr_pend_reg, wr_idx_reg, `IDX_RELOAD_HIGH))
        reload_high_reg <= wbyte;
      if (hit(wr_pend_reg, wr_idx_reg, `IDX_RELOAD_LOW))
        reload_low_reg <= wbyte;
      // start and stop bits are pulses, never stored
      if (hit(wr_pend_reg, wr_idx_reg, `IDX_CONTROL))
        control_reg <= {wbyte[`CTL_INIT_FIELD:`CTL_EVEN], 2'h0};
      if (hit(wr_pend_reg, wr_idx_reg, `IDX_IRQ_MASK))
        mask_reg <= wbyte[1:0];
    end
  end

  assign gate_source_select        = mode_reg[`MODE_GATE_HI:`MODE_GATE_LO];
  assign auto_reload_on_expiry     = mode_reg[`MODE_RESTART];
  assign protocol_auto_start       = mode_reg[`MODE_AUTO_START];
  assign multiple_reception_enable = control_reg[`CTL_MULTI_RX];
  assign initial_field_on_option   = control_reg[`CTL_INIT_FIELD];
  assign reload_value = {reload_high_reg, reload_low_reg};

  assign rd_mux =
    (rd_idx_reg == `IDX_MODE)        ? mode_reg :
    (rd_idx_reg == `IDX_PRESC_LOW)   ? presc_low_reg :
    (rd_idx_reg == `IDX_RELOAD_HIGH) ? reload_high_reg :
    (rd_idx_reg == `IDX_RELOAD_LOW)  ? reload_low_reg :
    (rd_idx_reg == `IDX_COUNT_HIGH)  ? count_reg[15:8] :
    (rd_idx_reg == `IDX_COUNT_LOW)   ? count_reg[7:0] :
    (rd_idx_reg == `IDX_CONTROL)     ? {active, 2'h0, control_reg} :
    (rd_idx_reg == `IDX_IRQ_STATUS)  ? {6'h00, tif.status} :
    (rd_idx_reg == `IDX_IRQ_MASK)    ? {6'h00, mask_reg} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // gate pin synchronisers

  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic       gate_ok;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= {address_pin_three, first_auxiliary_pin, serial_test_input_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign gate_ok =
    (gate_source_select == `GATE_SERIAL) ? pin_sync_reg[0] :
    (gate_source_select == `GATE_AUX)    ? pin_sync_reg[1] :
    (gate_source_select == `GATE_ADDR3)  ? pin_sync_reg[2] : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // timer core

  tick_divider u_div
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif)
  );

  irq_unit u_irq
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif)
  );

  timer_pkg::timer_state_t state_reg;
  logic [2:0]  rx_cnt_reg;
  logic        start_evt;
  logic        stop_now;
  logic        proto_stop;
  logic        count_tick;
  logic        expire;
  logic [2:0]  bit_limit;

  assign tif.prescale_value       = {mode_reg[3:0], presc_low_reg};
  assign tif.even_prescale_select = control_reg[`CTL_EVEN];
  assign tif.clear                = start_evt;
  assign tif.mask                 = mask_reg;
  assign tif.clear_bits           = hit(wr_pend_reg, wr_idx_reg, `IDX_IRQ_STATUS)
                                  ? wbyte[1:0] : 2'h0;
  assign irq                      = tif.irq;

  assign start_evt = (hit(wr_pend_reg, wr_idx_reg, `IDX_CONTROL) & wbyte[`CTL_START])
                   | (protocol_auto_start & (tx_end | (initial_field_on_option & field_on)));
  assign stop_now  = hit(wr_pend_reg, wr_idx_reg, `IDX_CONTROL) & wbyte[`CTL_STOP_NOW];
  assign bit_limit = fast_106_mode ? `BITS_FAST_MODE : `BITS_OTHER_MODE;
  assign proto_stop = protocol_auto_start & ~multiple_reception_enable & active & rx_bit
                    & ((rx_cnt_reg + 3'h1) == bit_limit);
  assign active     = (state_reg == timer_pkg::ST_RUN);
  assign count_tick = active & tif.tick & gate_ok;
  assign expire     = count_tick & (count_reg == 16'h0000);
  assign tif.events = {proto_stop & ~stop_now & ~start_evt, expire & ~stop_now & ~start_evt};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg  <= timer_pkg::ST_IDLE;
      count_reg  <= 16'h0000;
      rx_cnt_reg <= 3'h0;
    end
    else
    begin
      if (active && rx_bit)
        rx_cnt_reg <= rx_cnt_reg + 3'h1;
      case (state_reg)
        timer_pkg::ST_IDLE:
        begin
          if (start_evt && !stop_now)
          begin
            count_reg  <= reload_value;
            rx_cnt_reg <= 3'h0;
            state_reg  <= timer_pkg::ST_RUN;
          end
        end
        timer_pkg::ST_RUN:
        begin
          if (stop_now || proto_stop)
            state_reg <= timer_pkg::ST_IDLE;
          else if (start_evt)
          begin
            count_reg  <= reload_value;
            rx_cnt_reg <= 3'h0;
          end
          else if (expire)
          begin
            if (auto_reload_on_expiry)
              count_reg <= reload_value;
            else
              state_reg <= timer_pkg::ST_IDLE;
          end
          else if (count_tick)
            count_reg <= count_reg - 16'h0001;
        end
        default:
          state_reg <= timer_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [12:0] gap_reg;
  logic        gap_valid_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_reg       <= 13'h0000;
      gap_valid_reg <= 1'b0;
    end
    else if (tif.clear)
    begin
      gap_reg       <= 13'h0000;
      gap_valid_reg <= 1'b0;
    end
    else if (tif.tick)
    begin
      gap_reg       <= 13'h0000;
      gap_valid_reg <= 1'b1;
    end
    else
      gap_reg <= gap_reg + 13'h0001;
  end

  logic quiet;
  assign quiet = ~start_evt & ~stop_now & ~proto_stop;

  sequence s_oneshot_expiry;
    expire && !auto_reload_on_expiry && quiet;
  endsequence

  sequence s_restart_expiry;
    expire && auto_reload_on_expiry && quiet;
  endsequence

  property p_gate_blocks;
    active && quiet && tif.tick && !gate_ok |=> $stable(count_reg) && active;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks)
    else $error("count moved while gate closed");

  property p_restart;
    s_restart_expiry |=> active && count_reg == $past(reload_value);
  endproperty
  a_restart: assert property (p_restart)
    else $error("auto restart did not reload");

  property p_oneshot;
    s_oneshot_expiry |=> !active && tif.status[`IRQ_EXPIRED];
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("one-shot expiry did not stop and flag");

  property p_prescale;
    hit(wr_pend_reg, wr_idx_reg, `IDX_PRESC_LOW)
      |=> tif.prescale_value == {$past(mode_reg[3:0]), $past(wbyte)};
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescale value not nibble plus byte");

  property p_tick_period;
    tif.tick && gap_valid_reg && $stable(tif.prescale_value)
      && $stable(tif.even_prescale_select)
      |-> ({1'b0, gap_reg} + 14'h0001) == timer_pkg::calc_divisor(tif.prescale_value,
                                                                 tif.even_prescale_select);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick spacing differs from divisor");

  property p_reload_hold;
    active && quiet && !count_tick |=> $stable(count_reg);
  endproperty
  a_reload_hold: assert property (p_reload_hold)
    else $error("count changed without tick or start");

  property p_proto_stop;
    proto_stop && !stop_now && !start_evt |=> !active ##0 tif.status[`IRQ_PROTO_STOP];
  endproperty
  a_proto_stop: assert property (p_proto_stop)
    else $error("protocol stop not taken");

  property p_multi_rx;
    active && multiple_reception_enable && !stop_now && !expire |=> active;
  endproperty
  a_multi_rx: assert property (p_multi_rx)
    else $error("timer stopped by protocol in multi rx");

  property p_decrement;
    count_tick && quiet && count_reg != 16'h0000 |=> count_reg == $past(count_reg) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("count did not step down by one");

endmodule // prescaled_reload_down_timer

/* File: core/timer_consts.svh */
/*
  Constants of the prescaled reload down timer: register indices, field
  positions and reset values. Assumes a byte-wide register model placed on
  32-bit bus words, byte address equal to four times the index.
*/
// Contract
// - two-bit field picks gate source
// - running flag ignores gate level
// - auto restart reloads on expiry
// - no restart: reach zero, set irq
// - prescaler is twelve bits, nibble plus byte
// - odd mode divides by 2p plus 1
// - even mode divides by 2p plus 2
// - reload value sixteen bits in two bytes
// - reload taken only at start event or auto restart expiry
// - counter readable as two read-only bytes
// - auto start at transmit end or field
// - auto stop after fifth or fourth bit
// - multiple reception: only software or expiry stops timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define IDX_MODE        6'h2a
`define IDX_PRESC_LOW   6'h2b
`define IDX_RELOAD_HIGH 6'h2c
`define IDX_RELOAD_LOW  6'h2d
`define IDX_COUNT_HIGH  6'h2e
`define IDX_COUNT_LOW   6'h2f
`define IDX_CONTROL     6'h3c
`define IDX_IRQ_STATUS  6'h3d
`define IDX_IRQ_MASK    6'h3e

`define MODE_AUTO_START 7
`define MODE_GATE_HI    6
`define MODE_GATE_LO    5
`define MODE_RESTART    4
`define CTL_START       0
`define CTL_STOP_NOW    1
`define CTL_EVEN        2
`define CTL_MULTI_RX    3
`define CTL_INIT_FIELD  4
`define CTL_ACTIVE      7
`define IRQ_EXPIRED     0
`define IRQ_PROTO_STOP  1

`define RESET_BYTE      8'h00
`define GATE_NONE       2'h0
`define GATE_SERIAL     2'h1
`define GATE_AUX        2'h2
`define GATE_ADDR3      2'h3
`define BITS_FAST_MODE  3'h5
`define BITS_OTHER_MODE 3'h4

`endif

/* File: core/timer_pkg.sv */
/*
  Types and the divisor function of the timer. Assumes the constants header
  is available for callers; this package needs nothing else.
*/
package timer_pkg;

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} timer_state_t;

  // reference cycles per timer tick, one bit wider so 2p plus 2 cannot wrap
  function automatic logic [13:0] calc_divisor(input logic [11:0] p, input logic even);
    calc_divisor = {1'b0, p, 1'b0} + (even ? 14'h0002 : 14'h0001);
  endfunction

endpackage

/* File: core/timer_if.sv */
/*
  Interface between the timer core, its tick divider and its interrupt unit.
  Assumes all three parties run on one clock.
*/
`timescale 1ns/1ps
interface timer_if;
  logic [11:0] prescale_value;
  logic        even_prescale_select;
  logic        clear;
  logic        tick;
  logic [1:0]  events;
  logic [1:0]  mask;
  logic [1:0]  clear_bits;
  logic [1:0]  status;
  logic        irq;

  modport divider (input prescale_value, even_prescale_select, clear, output tick);
  modport irq_side (input events, mask, clear_bits, output status, irq);
  modport core (output prescale_value, even_prescale_select, clear, events, mask,
                clear_bits, input tick, status, irq);
endinterface

/* File: core/tick_divider.sv */
/*
  Prescaler: one-cycle tick every calc_divisor reference cycles.
  Assumes hclk is the reference clock and clear restarts the phase.
*/
`timescale 1ns/1ps
module tick_divider
(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  timer_if.divider    tif
);

  logic [12:0] cnt_reg;
  logic [13:0] divisor;
  logic        at_end;

  // odd or even divisor
  assign divisor = timer_pkg::calc_divisor(tif.prescale_value, tif.even_prescale_select);
  assign at_end  = ({1'b0, cnt_reg} + 14'h0001) >= divisor;
  assign tif.tick = at_end & ~tif.clear;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= 13'h0000;
    else if (tif.clear || at_end)
      cnt_reg <= 13'h0000;
    else
      cnt_reg <= cnt_reg + 13'h0001;
  end

endmodule // tick_divider

/* File: core/irq_unit.sv */
/*
  Sticky interrupt status with write-one-to-clear and a mask.
  Assumes events and clears are one-cycle pulses on hclk.
*/
`timescale 1ns/1ps
module irq_unit
(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  timer_if.irq_side   tif
);

  logic [1:0] status_reg;

  // a set in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_reg <= 2'h0;
    else
      status_reg <= (status_reg & ~tif.clear_bits) | tif.events;
  end

  assign tif.status = status_reg;
  assign tif.irq    = |(status_reg & tif.mask);

endmodule // irq_unit

/* File: tb/tb_prescaled_reload_down_timer.sv */
/*
  Self-checking bench of the prescaled reload down timer: AHB-Lite master
  tasks, a read monitor fed from a queue of expected bytes, timing checks.
  Assumes the design answers writes with no wait and reads with one wait.
*/
`timescale 1ns/1ps
`include "timer_consts.svh"
module tb_prescaled_reload_down_timer;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  pins;
  logic        tx_end;
  logic        field_on;
  logic        rx_bit;
  logic        fast_106_mode;
  logic        irq;
  logic        rd_phase = 1'b0;
  logic [31:0] notes[$];
  logic [7:0]  b;
  logic [1:0]  gs;
  int          fails;
  int          checked;
  logic [5:0]  rst_regs[8] = '{`IDX_MODE, `IDX_PRESC_LOW, `IDX_RELOAD_HIGH, `IDX_RELOAD_LOW,
                                `IDX_CONTROL, `IDX_IRQ_STATUS, `IDX_IRQ_MASK, 6'h10};

  assign hready = hreadyout;

  prescaled_reload_down_timer u_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_test_input_pin(pins[0]),
    .first_auxiliary_pin(pins[1]), .address_pin_three(pins[2]), .tx_end(tx_end),
    .field_on(field_on), .rx_bit(rx_bit), .fast_106_mode(fast_106_mode), .irq(irq)
  );

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic report(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (!ok)
    begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
    report(got === exp, got, exp);
  endtask

  task automatic check_span(input int got, input int exp);
    report((got >= exp - 4) && (got <= exp + 4), got, exp);
  endtask

  // irq settles after the edge that lands the write
  task automatic check_irq(input logic exp);
    @(negedge hclk);
    report(irq === exp, {31'h0, irq}, {31'h0, exp});
  endtask

  task automatic check_resp(input logic got);
    report(got === 1'b0, {31'h0, got}, 32'h0000_0000);
  endtask

  task automatic give_verdict();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // the monitor pops a note whenever a read data phase completes
  always @(posedge hclk)
  begin
    if (rd_phase && hready === 1'b1)
    begin
      check_read(hrdata, notes.pop_front());
      check_resp(hresp);
      rd_phase = 1'b0;
    end
    if (hsel === 1'b1 && htrans[1] === 1'b1 && hready === 1'b1 && hwrite === 1'b0)
      rd_phase = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus_addr(input logic [5:0] idx, input logic wr);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic bus_write(input logic [5:0] idx, input logic [7:0] d);
    bus_addr(idx, 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {24'h00_0000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic bus_read(input logic [5:0] idx, input logic [7:0] e);
    bus_addr(idx, 1'b0);
    notes.push_back({24'h00_0000, e});
    htrans <= 2'b00;
    hsel   <= 1'b0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic pulse(input logic tx, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      if (tx) tx_end <= 1'b1; else if (n == 1) field_on <= 1'b1; else rx_bit <= 1'b1;
      @(posedge hclk);
      tx_end   <= 1'b0;
      field_on <= 1'b0;
      rx_bit   <= 1'b0;
    end
  endtask

  task automatic set_timer(input logic [7:0] m, input logic [7:0] p, input logic [15:0] r);
    bus_write(`IDX_MODE, m);
    bus_write(`IDX_PRESC_LOW, p);
    bus_write(`IDX_RELOAD_HIGH, r[15:8]);
    bus_write(`IDX_RELOAD_LOW, r[7:0]);
  endtask

  // expiry after reload+1 ticks of 2p+1 or 2p+2 cycles, irq masked and cleared
  task automatic time_expiry(input logic even);
    int n;
    n = 0;
    bus_write(`IDX_CONTROL, {5'h00, even, 2'b01});
    while (irq !== 1'b1 && n < 20000)
    begin
      @(posedge hclk);
      n++;
    end
    check_span(n, 10 * (2 * 259 + (even ? 2 : 1)));
    bus_read(`IDX_CONTROL, {5'h00, even, 2'b00});
    bus_write(`IDX_IRQ_MASK, 8'h00);
    check_irq(1'b0);
    bus_write(`IDX_IRQ_MASK, 8'h01);
    check_irq(1'b1);
    bus_write(`IDX_IRQ_STATUS, 8'h01);
    bus_read(`IDX_IRQ_STATUS, 8'h00);
    check_irq(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {hsel, hwrite, tx_end, field_on, rx_bit, fast_106_mode} = '0;
    haddr = '0; htrans = 2'b00; hsize = 3'b010; hwdata = '0; pins = 3'b000;
    fails = 0; checked = 0; hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(66));
    foreach (rst_regs[i]) bus_read(rst_regs[i], 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($urandom);
      bus_write(rst_regs[i], b);
      bus_read(rst_regs[i], b);
    end
    bus_write(6'h10, 8'hff);
    bus_read(6'h10, 8'h00);
    // reload latched at start only
    set_timer(8'h00, 8'hff, 16'h1234);
    bus_write(`IDX_CONTROL, 8'h01);
    set_timer(8'h00, 8'hff, 16'h0000);
    bus_read(`IDX_COUNT_HIGH, 8'h12);
    bus_read(`IDX_COUNT_LOW, 8'h34);
    bus_read(`IDX_CONTROL, 8'h80);
    bus_write(`IDX_CONTROL, 8'h02);
    bus_read(`IDX_CONTROL, 8'h00);
    // auto restart keeps running
    set_timer(8'h10, 8'h00, 16'h0003);
    bus_write(`IDX_CONTROL, 8'h01);
    repeat (40) @(posedge hclk);
    bus_read(`IDX_CONTROL, 8'h80);
    bus_read(`IDX_IRQ_STATUS, 8'h01);
    bus_write(`IDX_CONTROL, 8'h02);
    bus_write(`IDX_IRQ_STATUS, 8'h01);
    set_timer(8'h01, 8'h03, 16'h0009);
    bus_write(`IDX_IRQ_MASK, 8'h01);
    time_expiry(1'b0);
    time_expiry(1'b1);
    bus_write(`IDX_IRQ_MASK, 8'h00);
    // gating by each source; other pins must not open the gate
    for (int g = 1; g < 4; g++)
    begin
      gs = g[1:0];
      set_timer({1'b0, gs, 5'h00}, 8'h00, 16'h0010);
      bus_write(`IDX_CONTROL, 8'h01);
      repeat (20) @(posedge hclk);
      bus_read(`IDX_COUNT_LOW, 8'h10);
      bus_read(`IDX_CONTROL, 8'h80);
      pins <= 3'b111 & ~(3'b001 << (g - 1));
      repeat (20) @(posedge hclk);
      bus_read(`IDX_COUNT_LOW, 8'h10);
      pins <= 3'b111;
      repeat (40) @(posedge hclk);
      bus_read(`IDX_IRQ_STATUS, 8'h01);
      pins <= 3'b000;
      bus_write(`IDX_IRQ_STATUS, 8'h01);
    end
    // protocol start and stop after the fourth or fifth bit
    set_timer(8'h80, 8'hff, 16'hffff);
    for (int f = 0; f < 2; f++)
    begin
      fast_106_mode <= f[0];
      pulse(1'b1, 1);
      bus_read(`IDX_CONTROL, 8'h80);
      pulse(1'b0, f ? 4 : 3);
      bus_read(`IDX_CONTROL, 8'h80);
      pulse(1'b0, 2);
      bus_read(`IDX_CONTROL, 8'h00);
      bus_read(`IDX_IRQ_STATUS, 8'h02);
      bus_write(`IDX_IRQ_STATUS, 8'h02);
    end
    bus_write(`IDX_CONTROL, 8'h08);
    pulse(1'b1, 1);
    pulse(1'b0, 6);
    bus_read(`IDX_CONTROL, 8'h88);
    bus_write(`IDX_CONTROL, 8'h0a);
    bus_read(`IDX_CONTROL, 8'h08);
    bus_write(`IDX_CONTROL, 8'h10);
    pulse(1'b0, 1);
    bus_read(`IDX_CONTROL, 8'h90);
    bus_write(`IDX_CONTROL, 8'h12);
    bus_read(`IDX_CONTROL, 8'h10);
    give_verdict();
  end

  // watchdog, well past the expected run of about 11000 cycles
  initial
  begin
    repeat (60000) @(posedge hclk);
    fails++;
    $display("unexpected at %0t: run timed out", $time);
    give_verdict();
  end
endmodule // tb_prescaled_reload_down_timer
